// ---- hw/timebase_pkg.sv ----
// constants and types shared by the periodic timebase design files
//==========================================================================
//==========================================================================
package timebase_pkg;

    localparam int unsigned CHAIN_BITS      = 15;
    localparam int unsigned PRESCALE_BITS   = 7;
    localparam int unsigned TAP_BITS        = 3;
    localparam int unsigned TAP_COUNT       = 8;
    localparam int unsigned PRESCALE_DIV    = 128;
    localparam int unsigned SYNC_STAGES     = 3;

    // chain bit that toggles once per half period, indexed by tap_select
    // dividers 32768,8192,2048,128,64,32,16,8 map to bits 14,12,10,6,5,4,3,2
    localparam logic [3:0] TAP_BIT [TAP_COUNT] = '{
        4'h000e, 4'h000c, 4'h000a, 4'h0006, 4'h0005, 4'h0004, 4'h0003, 4'h0002
    };

    localparam logic [CHAIN_BITS-1:0]    CHAIN_RESET    = 15'h0000;
    localparam logic [PRESCALE_BITS-1:0] PRESCALE_RESET = 7'h00;
    localparam logic [TAP_BITS-1:0]      TAP_RESET      = 3'h0;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_WAIT,
        MODE_STOP
    } power_mode_t;

endpackage : timebase_pkg

// ---- hw/pin_sync.sv ----
// three-stage synchroniser with agreement filter for an asynchronous level
`timescale 1ns/100ps
module pin_sync (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic clk_en,
    input  wire logic async_in,
    output logic      level_out
);
    logic [timebase_pkg::SYNC_STAGES-1:0] stage_r;

    // shift in; the first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage_r <= '0;
        end else if (clk_en) begin
            stage_r <= {stage_r[1:0], async_in};
        end
    end

    // change counts once the second and third stages agree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            level_out <= 1'b0;
        end else if (clk_en && (stage_r[1] == stage_r[2])) begin
            level_out <= stage_r[2];
        end
    end
endmodule : pin_sync

// ---- hw/periodic_timebase_interrupt.sv ----
// periodic timebase: divider chain, tap select, rollover flag and request
`timescale 1ns/100ps
module periodic_timebase_interrupt (
    input  wire logic                                ref_clk,
    input  wire logic                                rst,
    input  wire logic                                clk_en,
    input  wire logic                                oscillator_clock,
    input  wire logic                                prescale_128_select,
    input  wire logic                                osc_run_in_stop,
    input  wire logic                                wait_mode,
    input  wire logic                                stop_mode,
    input  wire logic                                ctrl_write,
    input  wire logic                                count_enable_wr,
    input  wire logic                                rollover_irq_enable_wr,
    input  wire logic [timebase_pkg::TAP_BITS-1:0]   tap_select_wr,
    input  wire logic                                flag_acknowledge,
    output logic                                     count_enable,
    output logic                                     rollover_irq_enable,
    output logic [timebase_pkg::TAP_BITS-1:0]        tap_select,
    output logic                                     rollover_flag,
    output logic                                     flag_acknowledge_rd,
    output logic                                     irq_request,
    output logic                                     wakeup_request
);
    //======================================================================
    // oscillator clock sampling
    //======================================================================
    logic osc_level;
    logic osc_prev_r;
    logic osc_rise;

    pin_sync u_osc_sync (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .clk_en    (clk_en),
        .async_in  (oscillator_clock),
        .level_out (osc_level)
    );

    // remember the filtered level to find rising edges
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            osc_prev_r <= 1'b0;
        end else if (clk_en) begin
            osc_prev_r <= osc_level;
        end
    end

    assign osc_rise = osc_level & ~osc_prev_r;

    //======================================================================
    // power mode and register access
    //======================================================================
    logic low_power;
    logic stop_halt;
    logic write_ok;

    assign low_power = wait_mode | stop_mode;
    assign stop_halt = stop_mode & ~osc_run_in_stop;
    assign write_ok  = ctrl_write & ~low_power;

    logic count_enable_r;
    logic irq_enable_r;
    logic [timebase_pkg::TAP_BITS-1:0] tap_r;

    // control bits; cleared by reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_enable_r <= 1'b0;
            irq_enable_r   <= 1'b0;
            tap_r          <= timebase_pkg::TAP_RESET;
        end else if (clk_en && write_ok) begin
            count_enable_r <= count_enable_wr;
            irq_enable_r   <= rollover_irq_enable_wr;
            tap_r          <= tap_select_wr;
        end
    end

    //======================================================================
    // prescaler and divider chain
    //======================================================================
    logic [timebase_pkg::PRESCALE_BITS-1:0] pre_r;
    logic [timebase_pkg::PRESCALE_BITS-1:0] pre_nxt;
    logic [timebase_pkg::CHAIN_BITS-1:0]    chain_r;
    logic [timebase_pkg::CHAIN_BITS-1:0]    chain_nxt;
    logic running;
    logic pre_wrap;
    logic chain_tick;

    assign running    = count_enable_r & ~stop_halt & osc_rise;
    assign pre_wrap   = (pre_r == 7'h007f);
    assign pre_nxt    = pre_r + 7'h01;
    assign chain_tick = running & (~prescale_128_select | pre_wrap);
    assign chain_nxt  = chain_r + 15'h0001;

    // chain is cleared while disabled so every enable starts from zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pre_r   <= timebase_pkg::PRESCALE_RESET;
            chain_r <= timebase_pkg::CHAIN_RESET;
        end else if (clk_en) begin
            if (!count_enable_r) begin
                pre_r   <= timebase_pkg::PRESCALE_RESET;
                chain_r <= timebase_pkg::CHAIN_RESET;
            end else begin
                if (running) begin
                    pre_r <= pre_nxt;
                end
                if (chain_tick) begin
                    chain_r <= chain_nxt;
                end
            end
        end
    end

    //======================================================================
    // tap rollover detection
    //======================================================================
    function automatic logic tap_value(input logic [timebase_pkg::CHAIN_BITS-1:0] chain,
                                       input logic [timebase_pkg::TAP_BITS-1:0]   sel);
        tap_value = chain[timebase_pkg::TAP_BIT[sel]];
    endfunction : tap_value

    logic tap_now;
    logic tap_next;
    logic rollover;

    assign tap_now  = tap_value(chain_r, tap_r);
    assign tap_next = tap_value(chain_nxt, tap_r);
    // tap bit rising: first at half period, then every full period
    assign rollover = chain_tick & ~tap_now & tap_next;

    //======================================================================
    // flag, request and outputs
    //======================================================================
    logic flag_r;
    logic flag_nxt;
    logic ack;

    assign ack      = write_ok & flag_acknowledge;
    assign flag_nxt = rollover | (flag_r & ~ack);

    // sticky flag; a set in the acknowledge cycle wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else if (clk_en) begin
            flag_r <= flag_nxt;
        end
    end

    // registered outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_enable        <= 1'b0;
            rollover_irq_enable <= 1'b0;
            tap_select          <= timebase_pkg::TAP_RESET;
            rollover_flag       <= 1'b0;
            flag_acknowledge_rd <= 1'b0;
            irq_request         <= 1'b0;
            wakeup_request      <= 1'b0;
        end else if (clk_en) begin
            count_enable        <= count_enable_r;
            rollover_irq_enable <= irq_enable_r;
            tap_select          <= tap_r;
            rollover_flag       <= flag_r;
            flag_acknowledge_rd <= 1'b0;
            irq_request         <= flag_r & irq_enable_r;
            wakeup_request      <= flag_r & irq_enable_r & stop_mode;
        end
    end
endmodule : periodic_timebase_interrupt

// ---- verification/timebase_assertions.sv ----
// port assertions for the periodic timebase
`timescale 1ns/100ps
module timebase_checker (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       ctrl_write,
    input wire logic       wait_mode,
    input wire logic       stop_mode,
    input wire logic       osc_run_in_stop,
    input wire logic       flag_acknowledge,
    input wire logic       count_enable,
    input wire logic       rollover_irq_enable,
    input wire logic [2:0] tap_select,
    input wire logic       rollover_flag,
    input wire logic       flag_acknowledge_rd,
    input wire logic       irq_request,
    input wire logic       wakeup_request
);
    //==========================================================================
    // checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // control write that the block accepts
    wire logic wr_ok = ctrl_write & ~wait_mode & ~stop_mode;
    sequence s_dead_stop;
        (stop_mode && !osc_run_in_stop)[*3];
    endsequence
    sequence s_idle;
        (!count_enable)[*4];
    endsequence
    a_reset_clears: assert property ($fell(rst) |-> !count_enable && !rollover_irq_enable && !rollover_flag)
        else $error("outputs not cleared by reset");
    a_enable_cause: assert property ($changed(count_enable) |-> $past(wr_ok, 2))
        else $error("enable changed without an accepted write");
    a_field_cause: assert property ($changed(tap_select) || $changed(rollover_irq_enable) |-> $past(wr_ok, 2))
        else $error("control field changed without an accepted write");
    a_flag_clear: assert property ($fell(rollover_flag) |-> $past(wr_ok && flag_acknowledge, 2))
        else $error("flag cleared without acknowledge");
    a_ack_reads_zero: assert property (!flag_acknowledge_rd)
        else $error("acknowledge reads back one");
    a_irq_tracks: assert property (irq_request == (rollover_flag && rollover_irq_enable))
        else $error("request does not follow flag and enable");
    a_wake_tracks: assert property (wakeup_request == (irq_request && $past(stop_mode)))
        else $error("wakeup does not follow request in stop");
    a_stop_idle: assert property (s_dead_stop |=> !$rose(rollover_flag))
        else $error("flag rose in stop without oscillator");
    a_off_idle: assert property (s_idle |=> !$rose(rollover_flag))
        else $error("flag rose while disabled");
endmodule : timebase_checker
bind periodic_timebase_interrupt timebase_checker u_chk (.ref_clk(ref_clk), .rst(rst), .ctrl_write(ctrl_write),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .osc_run_in_stop(osc_run_in_stop),
    .flag_acknowledge(flag_acknowledge), .count_enable(count_enable), .rollover_irq_enable(rollover_irq_enable),
    .tap_select(tap_select), .rollover_flag(rollover_flag), .flag_acknowledge_rd(flag_acknowledge_rd),
    .irq_request(irq_request), .wakeup_request(wakeup_request));

// ---- verification/periodic_timebase_interrupt_bench.sv ----
// self-checking bench for the periodic timebase
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module periodic_timebase_interrupt_bench;
    //==========================================================================
    // stimulus and helpers
    logic ref_clk = 0, rst = 1, clk_en = 1, oscillator_clock = 0, prescale_128_select = 0, osc_run_in_stop = 0;
    logic wait_mode = 0, stop_mode = 0, ctrl_write = 0, count_enable_wr = 0, rollover_irq_enable_wr = 0;
    logic flag_acknowledge = 0, count_enable, rollover_irq_enable, rollover_flag, flag_acknowledge_rd;
    logic irq_request, wakeup_request;
    logic [2:0] tap_select_wr = 3'h0, tap_select;
    logic [31:0] seed = 32'hb5e2_1c57;
    int miscompares = 0, total_checks = 0, ticks = 0, t0, n;
    periodic_timebase_interrupt DUT (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .oscillator_clock(oscillator_clock), .prescale_128_select(prescale_128_select),
        .osc_run_in_stop(osc_run_in_stop), .wait_mode(wait_mode), .stop_mode(stop_mode), .ctrl_write(ctrl_write),
        .count_enable_wr(count_enable_wr), .rollover_irq_enable_wr(rollover_irq_enable_wr),
        .tap_select_wr(tap_select_wr), .flag_acknowledge(flag_acknowledge), .count_enable(count_enable),
        .rollover_irq_enable(rollover_irq_enable), .tap_select(tap_select), .rollover_flag(rollover_flag),
        .flag_acknowledge_rd(flag_acknowledge_rd), .irq_request(irq_request), .wakeup_request(wakeup_request));
    always #5 ref_clk = ~ref_clk;
    always #60 oscillator_clock = ~oscillator_clock; // source well below a quarter of ref_clk
    always @(posedge oscillator_clock) ticks++;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic int div_of(int tap, logic pre);
        int d[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
        return pre ? d[tap] * 128 : d[tap];
    endfunction : div_of
    // one control write, accepted outside wait and stop, then wait until the copies reach the ports
    task automatic wr(logic en, logic ie, int tap, logic ack);
        @(posedge ref_clk);
        ctrl_write <= 1;
        count_enable_wr <= en;
        rollover_irq_enable_wr <= ie;
        tap_select_wr <= 3'(tap);
        flag_acknowledge <= ack;
        @(posedge ref_clk);
        ctrl_write <= 0;
        flag_acknowledge <= 0;
        repeat (2) @(posedge ref_clk);
    endtask : wr
    task automatic rise(int lim);
        n = 0;
        while (rollover_flag !== 1'b1 && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= lim) `CHK(n, 0)
    endtask : rise
    // first event at half period, later ones at the full divider
    task automatic period(int tap, logic pre);
        int d;
        logic [31:0] r;
        d = div_of(tap, pre);
        r = rnd();
        prescale_128_select <= pre;
        wr(0, 0, tap, 1);
        t0 = ticks;
        wr(1, r[0], tap, 0);
        `CHK({count_enable, rollover_irq_enable, tap_select}, {1'b1, r[0], 3'(tap)})
        rise(d * 15);
        `CHK((ticks - t0) inside {[d / 2 - 1 : d / 2 + 1]}, 1'b1)
        `CHK(irq_request, r[0])
        t0 = ticks;
        wr(1, r[0], tap, 0);
        `CHK({rollover_flag, flag_acknowledge_rd}, 2'h2)
        wr(1, r[0], tap, 1);
        `CHK(rollover_flag, 1'b0)
        rise(d * 15);
        `CHK(ticks - t0, d)
        wr(0, 0, tap, 1);
        $display("test tap %0d prescale %0b done", tap, pre);
    endtask : period
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    initial begin
        #1_000_000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 0;
        @(posedge ref_clk);
        `CHK({count_enable, rollover_irq_enable, tap_select, rollover_flag}, 6'h00)
        for (int t = 2; t < 8; t++) period(t, 0);
        period(7, 1);
        // wait mode refuses writes but keeps counting; short divider so the waits below suffice
        prescale_128_select <= 0;
        wr(1, 1, 7, 1);
        wait_mode <= 1;
        wr(0, 0, 3, 1);
        `CHK({count_enable, tap_select}, 4'hf)
        rise(2000);
        wait_mode <= 0;
        wr(1, 1, 7, 1);
        // stop without oscillator stays idle, with it wakes the part
        stop_mode <= 1;
        repeat (300) @(posedge ref_clk);
        `CHK(rollover_flag, 1'b0)
        osc_run_in_stop <= 1;
        rise(2000);
        @(posedge ref_clk);
        `CHK(wakeup_request, 1'b1)
        stop_mode <= 0;
        wr(0, 0, 7, 1);
        $display("test low power done");
        test_done();
    end
endmodule : periodic_timebase_interrupt_bench
